//--- pkg/ocd_pkg.sv
package ocd_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [9:0] ADDR_CH2_PWR = 10'h198;
  localparam logic [9:0] ADDR_CH3_COUNTS = 10'h199;
  localparam logic [9:0] ADDR_CH3_CTRL = 10'h19A;
  localparam logic [9:0] ADDR_CH3_PWR = 10'h19B;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CNT_LOW_LSB = 4;
  localparam int CNT_HIGH_LSB = 0;
  localparam int CTRL_BYPASS = 7;
  localparam int CTRL_IGN_SYNC = 6;
  localparam int CTRL_FORCE = 5;
  localparam int CTRL_START_HIGH = 4;
  localparam int CTRL_PHASE_LSB = 0;
  localparam int PWR_PD = 2;
  localparam int PWR_DIRECT = 1;
  localparam int PWR_DCC_OFF = 0;
  localparam int PWR_WIDTH = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CH3_COUNTS = 8'h00;
  localparam logic [7:0] RST_CH3_CTRL = 8'h00;
  localparam logic [2:0] RST_PWR = 3'h0;

  // ----------------------------------------
  // input-select codes for direct routing
  // ----------------------------------------
  localparam logic [1:0] SEL_EXT_CLK = 2'h0;
  localparam logic [1:0] SEL_OSC = 2'h2;

  // ----------------------------------------
  // divider states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_LOW,
    ST_HIGH
  } ocd_state_t;
endpackage

//--- pkg/ocd_div_if.sv
`timescale 1ns/1ps
interface ocd_div_if #(
  parameter int CW = 4
);
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] high_cnt;
  logic [CW-1:0] phase;
  logic start_high;
  logic ignore_sync;
  logic force_sel;
  logic bypass;
  logic pd;
  logic sync;
  logic div_out;

  modport cfg (
    output low_cnt, high_cnt, phase, start_high, ignore_sync, force_sel, bypass, pd, sync,
    input div_out
  );
  modport div (
    input low_cnt, high_cnt, phase, start_high, ignore_sync, force_sel, bypass, pd, sync,
    output div_out
  );
endinterface

//--- rtl/ocd_div.sv
`timescale 1ns/1ps
module ocd_div #(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration and output
  ocd_div_if.div bus
);
  // ----------------------------------------
  // counter state machine
  // ----------------------------------------
  ocd_pkg::ocd_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic out_q;
  wire hold = bus.pd | bus.bypass | (bus.sync & ~bus.ignore_sync);
  wire last_wait = (cnt_q == bus.phase);
  wire last_low = (cnt_q == bus.low_cnt);
  wire last_high = (cnt_q == bus.high_cnt);
  wire forced = bus.ignore_sync & ~bus.bypass;
  wire force_lvl = bus.force_sel & bus.start_high;

  // next state; phase wait then alternating low and high segments
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    if (hold) begin
      state_d = ocd_pkg::ST_WAIT;
      cnt_d = '0;
    end else begin
      case (state_q)
        ocd_pkg::ST_WAIT: begin
          if (last_wait) begin
            state_d = bus.start_high ? ocd_pkg::ST_HIGH : ocd_pkg::ST_LOW;
            cnt_d = '0;
          end
        end
        ocd_pkg::ST_LOW: begin
          if (last_low) begin
            state_d = ocd_pkg::ST_HIGH;
            cnt_d = '0;
          end
        end
        ocd_pkg::ST_HIGH: begin
          if (last_high) begin
            state_d = ocd_pkg::ST_LOW;
            cnt_d = '0;
          end
        end
        default: begin
          state_d = ocd_pkg::ST_WAIT;
          cnt_d = '0;
        end
      endcase
    end
  end

  // output level; forcing needs ignore-sync and never touches a bypassed divider
  wire lvl_d = (state_d == ocd_pkg::ST_HIGH) | ((state_d == ocd_pkg::ST_WAIT) & bus.start_high);
  wire out_d = bus.bypass ? 1'b0 : (forced ? force_lvl : lvl_d);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ocd_pkg::ST_WAIT;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign bus.div_out = out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // segment length helper: cycles since the last level change of a free-running divider
  logic [CW:0] seg_q;
  logic seg_ok_q;
  logic [2*CW-1:0] cfg_q;
  wire free = ~hold & ~forced;
  // a count rewritten mid-segment can let the counter wrap, so that segment is not measured
  wire cfg_chg = (cfg_q != {bus.low_cnt, bus.high_cnt});
  always_ff @(posedge i_clk) begin
    cfg_q <= {bus.low_cnt, bus.high_cnt};
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || !free || cfg_chg) begin
      seg_q <= '0;
      seg_ok_q <= 1'b0;
    end else if (out_d != out_q) begin
      seg_q <= '0;
      seg_ok_q <= (state_q != ocd_pkg::ST_WAIT);
    end else begin
      seg_q <= seg_q + 1'b1;
    end
  end

  AST_LOW_LEN:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (free && seg_ok_q && state_q == ocd_pkg::ST_LOW && state_d == ocd_pkg::ST_HIGH && $stable(bus.low_cnt))
      |-> seg_q == {1'b0, bus.low_cnt})
    else $error("low segment length differs from low count plus one");
  AST_HIGH_LEN:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (free && seg_ok_q && state_q == ocd_pkg::ST_HIGH && state_d == ocd_pkg::ST_LOW && $stable(bus.high_cnt))
      |-> seg_q == {1'b0, bus.high_cnt})
    else $error("high segment length differs from high count plus one");
  AST_BYPASS_IDLE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      bus.bypass |=> !bus.div_out && state_q == ocd_pkg::ST_WAIT)
    else $error("bypassed divider still running");
  AST_FORCE_LVL:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (bus.ignore_sync && !bus.bypass) |=> bus.div_out == $past(bus.force_sel & bus.start_high))
    else $error("forced level wrong");
  AST_SYNC_HOLD:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (bus.sync && !bus.ignore_sync && !bus.bypass && !bus.pd) [*2] |-> bus.div_out == $past(bus.start_high))
    else $error("divider not held at start level during sync");
  AST_PHASE_WAIT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!free ##1 free && bus.phase == 4'h2 && $stable(bus.phase) && !bus.start_high) |->
      state_q == ocd_pkg::ST_WAIT ##1 state_q == ocd_pkg::ST_WAIT ##1 state_q == ocd_pkg::ST_WAIT)
    else $error("phase wait shorter than phase offset");
endmodule

//--- rtl/ocd_top.sv
`timescale 1ns/1ps
// What this block does
// - low time is low count plus one
// - high time is high count plus one
// - bypass stops divider and holds its output low
// - ignore-sync bit makes divider disregard sync
// - forced level is zero or start bit
// - forcing has no effect when bypassed
// - start bit chooses initial output level
// - four-bit phase offset, resets to zero
// - channel three power-down idles outputs nine-eleven
// - channel two power-down idles outputs six-eight
// - channel two direct route picks oscillator/external
// - channel three direct route picks oscillator/external
// - power bit zero disables duty-cycle correction
module ocd_top #(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [9:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // chip-level inputs
  input wire logic i_sync,
  input wire logic [1:0] i_input_select,
  input wire logic i_osc_lvl,
  input wire logic i_ext_clk_lvl,
  input wire logic i_div2_out,
  input wire logic i_ch3_invert,
  // channel two outputs
  output logic [2:0] o_ch2_outs,
  output logic o_ch2_pd,
  output logic o_ch2_dcc_en,
  // channel three outputs
  output logic [2:0] o_ch3_outs,
  output logic o_ch3_pd,
  output logic o_ch3_dcc_en,
  output logic o_ch3_bypass
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] meta_q, sync_q;
  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {i_sync, i_osc_lvl, i_ext_clk_lvl, i_ch3_invert};
      sync_q <= meta_q;
    end
  end
  wire sync_s = sync_q[3];
  wire osc_s = sync_q[2];
  wire ext_s = sync_q[1];
  wire inv_s = sync_q[0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ch3_counts_q;
  logic [7:0] ch3_ctrl_q;
  logic [2:0] ch3_pwr_q;
  logic [2:0] ch2_pwr_q;
  wire wr_counts = i_reg_wr & (i_reg_addr == ocd_pkg::ADDR_CH3_COUNTS);
  wire wr_ctrl = i_reg_wr & (i_reg_addr == ocd_pkg::ADDR_CH3_CTRL);
  wire wr_ch3_pwr = i_reg_wr & (i_reg_addr == ocd_pkg::ADDR_CH3_PWR);
  wire wr_ch2_pwr = i_reg_wr & (i_reg_addr == ocd_pkg::ADDR_CH2_PWR);

  // writes to unmapped addresses are dropped; unused bits [7:3] are not stored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ch3_counts_q <= ocd_pkg::RST_CH3_COUNTS;
      ch3_ctrl_q <= ocd_pkg::RST_CH3_CTRL;
      ch3_pwr_q <= ocd_pkg::RST_PWR;
      ch2_pwr_q <= ocd_pkg::RST_PWR;
    end else begin
      if (wr_counts) ch3_counts_q <= i_reg_wdata;
      if (wr_ctrl) ch3_ctrl_q <= i_reg_wdata;
      if (wr_ch3_pwr) ch3_pwr_q <= i_reg_wdata[ocd_pkg::PWR_WIDTH-1:0];
      if (wr_ch2_pwr) ch2_pwr_q <= i_reg_wdata[ocd_pkg::PWR_WIDTH-1:0];
    end
  end

  // read data registered one cycle after the address; unmapped reads return zero
  logic [7:0] rdata_d;
  always_comb begin
    case (i_reg_addr)
      ocd_pkg::ADDR_CH3_COUNTS: rdata_d = ch3_counts_q;
      ocd_pkg::ADDR_CH3_CTRL: rdata_d = ch3_ctrl_q;
      ocd_pkg::ADDR_CH3_PWR: rdata_d = {5'h00, ch3_pwr_q};
      ocd_pkg::ADDR_CH2_PWR: rdata_d = {5'h00, ch2_pwr_q};
      default: rdata_d = 8'h00;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) o_reg_rdata <= 8'h00;
    else o_reg_rdata <= rdata_d;
  end

  // ----------------------------------------
  // channel three divider
  // ----------------------------------------
  ocd_div_if #(.CW(CW)) div3 ();
  assign div3.low_cnt = ch3_counts_q[ocd_pkg::CNT_LOW_LSB +: CW];
  assign div3.high_cnt = ch3_counts_q[ocd_pkg::CNT_HIGH_LSB +: CW];
  assign div3.phase = ch3_ctrl_q[ocd_pkg::CTRL_PHASE_LSB +: CW];
  assign div3.start_high = ch3_ctrl_q[ocd_pkg::CTRL_START_HIGH];
  assign div3.ignore_sync = ch3_ctrl_q[ocd_pkg::CTRL_IGN_SYNC];
  assign div3.force_sel = ch3_ctrl_q[ocd_pkg::CTRL_FORCE];
  assign div3.bypass = ch3_ctrl_q[ocd_pkg::CTRL_BYPASS];
  assign div3.pd = ch3_pwr_q[ocd_pkg::PWR_PD];
  assign div3.sync = sync_s;

  ocd_div #(.CW(CW)) u_div3 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(div3.div)
  );

  // ----------------------------------------
  // output routing
  // ----------------------------------------
  // direct source per input-select code; code 01b and 11b leave the divider in place
  function automatic logic route_sel(input logic direct, input logic [1:0] sel, input logic div_lvl,
                                     input logic osc, input logic ext);
    logic r;
    r = div_lvl;
    if (direct && sel == ocd_pkg::SEL_OSC) r = osc;
    else if (direct && sel == ocd_pkg::SEL_EXT_CLK) r = ext;
    return r;
  endfunction

  wire ch2_src = route_sel(ch2_pwr_q[ocd_pkg::PWR_DIRECT], i_input_select, i_div2_out, osc_s, ext_s);
  wire ch3_src = route_sel(ch3_pwr_q[ocd_pkg::PWR_DIRECT], i_input_select, div3.div_out, osc_s, ext_s);
  // polarity stays available even in bypass, since it acts after the divider
  wire ch3_lvl = ch3_src ^ inv_s;

  // safe power-down drives all three pairs low; registered so outputs never glitch
  logic [2:0] ch2_outs_q, ch3_outs_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ch2_outs_q <= 3'h0;
      ch3_outs_q <= 3'h0;
    end else begin
      ch2_outs_q <= ch2_pwr_q[ocd_pkg::PWR_PD] ? 3'h0 : {3{ch2_src}};
      ch3_outs_q <= ch3_pwr_q[ocd_pkg::PWR_PD] ? 3'h0 : {3{ch3_lvl}};
    end
  end
  assign o_ch2_outs = ch2_outs_q;
  assign o_ch3_outs = ch3_outs_q;
  assign o_ch2_pd = ch2_pwr_q[ocd_pkg::PWR_PD];
  assign o_ch3_pd = ch3_pwr_q[ocd_pkg::PWR_PD];
  assign o_ch2_dcc_en = ~ch2_pwr_q[ocd_pkg::PWR_DCC_OFF];
  assign o_ch3_dcc_en = ~ch3_pwr_q[ocd_pkg::PWR_DCC_OFF];
  assign o_ch3_bypass = div3.bypass;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CH3_PD_SAFE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_ch3_pd |=> o_ch3_outs == 3'h0)
    else $error("channel three outputs active while powered down");
  AST_CH2_PD_SAFE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_ch2_pd |=> o_ch2_outs == 3'h0)
    else $error("channel two outputs active while powered down");
  AST_CH2_ROUTE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch2_pd && ch2_pwr_q[ocd_pkg::PWR_DIRECT] && i_input_select == ocd_pkg::SEL_OSC)
      |=> o_ch2_outs == {3{$past(osc_s)}})
    else $error("channel two not routed to oscillator");
  AST_CH3_ROUTE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch3_pd && !ch3_pwr_q[ocd_pkg::PWR_DIRECT]) |=> o_ch3_outs == {3{$past(div3.div_out ^ inv_s)}})
    else $error("channel three not fed from divider");
  AST_DCC:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ch3_pwr |=> o_ch3_dcc_en == !$past(i_reg_wdata[ocd_pkg::PWR_DCC_OFF]))
    else $error("duty-cycle correction enable wrong");
  AST_PHASE_RB:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ctrl ##1 (i_reg_addr == ocd_pkg::ADDR_CH3_CTRL && !i_reg_wr) |=> o_reg_rdata[3:0] == $past(i_reg_wdata[3:0], 2))
    else $error("phase offset readback wrong");

  // register flags and the routing cases not covered above, select code 11b aside
  AST_CH3_BYPASS_FLAG:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ctrl |=> o_ch3_bypass == $past(i_reg_wdata[ocd_pkg::CTRL_BYPASS]))
    else $error("bypass flag does not follow the written bit");
  AST_CH3_BYPASS_INV:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ch3_bypass ##1 (o_ch3_bypass && !o_ch3_pd && !ch3_pwr_q[ocd_pkg::PWR_DIRECT])) |=> o_ch3_outs == {3{$past(inv_s)}})
    else $error("bypassed channel three does not show the polarity setting");
  AST_CH3_PD_FLAG:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ch3_pwr |=> o_ch3_pd == $past(i_reg_wdata[ocd_pkg::PWR_PD]))
    else $error("channel three power-down flag wrong");
  AST_CH2_PD_FLAG:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ch2_pwr |=> o_ch2_pd == $past(i_reg_wdata[ocd_pkg::PWR_PD]))
    else $error("channel two power-down flag wrong");
  AST_CH2_DCC:
    assert property (@(posedge i_clk) disable iff (i_rst)
      wr_ch2_pwr |=> o_ch2_dcc_en == !$past(i_reg_wdata[ocd_pkg::PWR_DCC_OFF]))
    else $error("channel two duty-cycle correction enable wrong");
  AST_CH2_EXT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch2_pd && ch2_pwr_q[ocd_pkg::PWR_DIRECT] && i_input_select == ocd_pkg::SEL_EXT_CLK)
      |=> o_ch2_outs == {3{$past(ext_s)}})
    else $error("channel two not routed to external clock");
  AST_CH2_DIV:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch2_pd && (!ch2_pwr_q[ocd_pkg::PWR_DIRECT] || i_input_select == 2'h1)) |=> o_ch2_outs == {3{$past(i_div2_out)}})
    else $error("channel two not fed from divider two");
  AST_CH3_OSC:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch3_pd && ch3_pwr_q[ocd_pkg::PWR_DIRECT] && i_input_select == ocd_pkg::SEL_OSC)
      |=> o_ch3_outs == {3{$past(osc_s ^ inv_s)}})
    else $error("channel three not routed to oscillator");
  AST_CH3_EXT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch3_pd && ch3_pwr_q[ocd_pkg::PWR_DIRECT] && i_input_select == ocd_pkg::SEL_EXT_CLK)
      |=> o_ch3_outs == {3{$past(ext_s ^ inv_s)}})
    else $error("channel three not routed to external clock");
  AST_CH3_NO_EFFECT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_ch3_pd && ch3_pwr_q[ocd_pkg::PWR_DIRECT] && i_input_select == 2'h1)
      |=> o_ch3_outs == {3{$past(div3.div_out ^ inv_s)}})
    else $error("select code one changed channel three routing");
endmodule

//--- bench/ocd_top_tb.sv
`timescale 1ns/1ps
module ocd_top_tb;
  // ----------------------------------------
  // stimulus and observed nets
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [9:0] i_reg_addr = 10'h000;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_sync = 1'b0;
  logic [1:0] i_input_select = 2'h1;
  logic i_osc_lvl = 1'b0;
  logic i_ext_clk_lvl = 1'b0;
  logic i_div2_out = 1'b0;
  logic i_ch3_invert = 1'b0;
  logic [7:0] o_reg_rdata;
  logic [2:0] o_ch2_outs, o_ch3_outs;
  logic o_ch2_pd, o_ch2_dcc_en, o_ch3_pd, o_ch3_dcc_en, o_ch3_bypass;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] mdl [int];

  // 200 MHz divider input clock
  always #2.5 i_clk = ~i_clk;

  ocd_top #(.CW(4)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_sync(i_sync),
    .i_input_select(i_input_select), .i_osc_lvl(i_osc_lvl), .i_ext_clk_lvl(i_ext_clk_lvl),
    .i_div2_out(i_div2_out), .i_ch3_invert(i_ch3_invert), .o_ch2_outs(o_ch2_outs),
    .o_ch2_pd(o_ch2_pd), .o_ch2_dcc_en(o_ch2_dcc_en), .o_ch3_outs(o_ch3_outs),
    .o_ch3_pd(o_ch3_pd), .o_ch3_dcc_en(o_ch3_dcc_en), .o_ch3_bypass(o_ch3_bypass)
  );

  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  // power registers keep only three bits; unmapped places hold nothing
  function automatic logic [7:0] mask(input logic [9:0] a);
    if (a == ocd_pkg::ADDR_CH2_PWR || a == ocd_pkg::ADDR_CH3_PWR) return 8'h07;
    if (a == ocd_pkg::ADDR_CH3_COUNTS || a == ocd_pkg::ADDR_CH3_CTRL) return 8'hFF;
    return 8'h00;
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // sampling 1 ns after the edge keeps clear of the design's own updates
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wr <= 1'b1;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    if (mask(a) != 8'h00) mdl[a] = d & mask(a);
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge i_clk);
    i_reg_addr <= a;
    tick(1);
    chk(o_reg_rdata, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask

  // bounded wait; a hang here ends the run as a failure
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (o_ch3_outs[0] !== v) begin
      tick(1);
      n++;
      if (n > 200) begin
        num_errors++;
        close_out();
      end
    end
  endtask

  task automatic runs(input int lo, input int hi);
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    chk(o_ch3_outs, {3{o_ch3_outs[0]}});
    wait_lvl(1'b0, n);
    chk(8'(n), 8'(hi));
    wait_lvl(1'b1, n);
    chk(8'(n), 8'(lo));
  endtask

  // holds sync, checks the held level, returns cycles from release to first rise
  task automatic sync_delay(input logic s, output int n);
    @(posedge i_clk);
    i_sync <= 1'b1;
    tick(8);
    repeat (3) begin
      chk(o_ch3_outs, {3{s}});
      tick(1);
    end
    @(posedge i_clk);
    i_sync <= 1'b0;
    wait_lvl(1'b1, n);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int unsigned seed;
    int n0, n1, p;
    logic [7:0] cv [4];
    logic [7:0] fv [4];
    seed = $urandom(32'h05AB5BB2);
    tick(11);
    chk(o_ch3_outs, 3'h0);
    @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    chk({o_ch2_dcc_en, o_ch3_dcc_en, o_ch2_pd, o_ch3_pd, o_ch3_bypass}, 8'h18);
    for (int a = 'h198; a < 'h19C; a++) rd(10'(a));
    runs(1, 1);
    cv = '{8'hF0, 8'h0F, 8'($urandom), 8'($urandom)};
    foreach (cv[i]) begin
      wr(ocd_pkg::ADDR_CH3_COUNTS, cv[i]);
      runs(int'(cv[i][7:4]) + 1, int'(cv[i][3:0]) + 1);
    end
    wr(ocd_pkg::ADDR_CH3_COUNTS, 8'h12);
    wr(ocd_pkg::ADDR_CH3_CTRL, 8'h02);
    sync_delay(1'b0, n0);
    p = $urandom_range(15, 1);
    wr(ocd_pkg::ADDR_CH3_CTRL, 8'(p));
    sync_delay(1'b0, n1);
    chk(8'(n1 - n0), 8'(p - 2));
    wr(ocd_pkg::ADDR_CH3_CTRL, 8'h10);
    sync_delay(1'b1, n0);
    // forced levels: ignore only, ignore+force low/high, ignore+start without force
    fv = '{8'h40, 8'h60, 8'h70, 8'h50};
    foreach (fv[i]) begin
      wr(ocd_pkg::ADDR_CH3_CTRL, fv[i]);
      @(posedge i_clk);
      i_sync <= i[0];
      tick(8);
      chk(o_ch3_outs, {3{fv[i][5] & fv[i][4]}});
    end
    i_sync <= 1'b0;
    wr(ocd_pkg::ADDR_CH3_CTRL, 8'hF0);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_ch3_invert <= k[0];
      tick(8);
      chk({o_ch3_bypass, o_ch3_outs}, {1'b1, {3{k[0]}}});
    end
    i_ch3_invert <= 1'b0;
    wr(ocd_pkg::ADDR_CH3_CTRL, 8'h40);
    wr(ocd_pkg::ADDR_CH3_PWR, 8'h02);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_input_select <= k[1:0];
      i_osc_lvl <= k[2];
      i_ext_clk_lvl <= ~k[2];
      tick(8);
      chk(o_ch3_outs, {3{k[1:0] == 2 ? k[2] : k[1:0] == 0 ? ~k[2] : 1'b0}});
    end
    @(posedge i_clk);
    i_input_select <= 2'h2;
    i_osc_lvl <= 1'b1;
    i_div2_out <= 1'b1;
    wr(ocd_pkg::ADDR_CH3_PWR, 8'h07);
    tick(8);
    chk({o_ch3_pd, o_ch3_dcc_en, o_ch3_outs}, 8'h10);
    wr(ocd_pkg::ADDR_CH2_PWR, 8'h00);
    tick(8);
    chk(o_ch2_outs, 3'h7);
    wr(ocd_pkg::ADDR_CH2_PWR, 8'h02);
    @(posedge i_clk);
    i_osc_lvl <= 1'b0;
    tick(8);
    chk(o_ch2_outs, 3'h0);
    @(posedge i_clk);
    i_input_select <= 2'h0;
    i_ext_clk_lvl <= 1'b1;
    tick(8);
    chk(o_ch2_outs, 3'h7);
    wr(ocd_pkg::ADDR_CH2_PWR, 8'h07);
    tick(8);
    chk({o_ch2_pd, o_ch2_dcc_en, o_ch2_outs}, 8'h10);
    // random readback, the unmapped place included
    repeat (12) begin
      p = $urandom_range(16'h19C, 16'h198);
      wr(10'(p), 8'($urandom));
      rd(10'(p));
    end
    rd(10'h000);
    close_out();
  end
endmodule
